// ===== rtl/sbcs_calc.sv
// Purpose: Background current and power computation
// Assumes: Operands stay stable from start until done
// Notes:   Two pipeline steps; results hold until the next start, current changing a cycle before done
`timescale 1ns/1ps
`default_nettype none
module sbcs_calc
   import sbcs_pkg::*;
(
   input  wire logic   clk_sys,
   input  wire logic   arst_n,
   sbcs_calc_if.calc   cif
);
   logic               step_q,  step_d;
   logic               done_q,  done_d;
   logic signed [15:0] cur_q,   cur_d;
   logic signed [15:0] pwr_q,   pwr_d;
   logic signed [32:0] prod_c;
   logic signed [33:0] prod_p;

   always_comb
   begin
      prod_c = cif.shunt * $signed({1'b0, cif.cal});
      prod_p = 34'(cur_q * cif.bus) / PWR_DIV;
      step_d = cif.start;
      done_d = step_q;
      cur_d  = cur_q;
      pwr_d  = pwr_q;
      if (cif.start)
         cur_d = prod_c[CUR_SHIFT +: 16];
      if (step_q)
         pwr_d = prod_p[15:0];
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         step_q <= 1'b0;
         done_q <= 1'b0;
         cur_q  <= 16'sh0000;
         pwr_q  <= 16'sh0000;
      end
      else
      begin
         step_q <= step_d;
         done_q <= done_d;
         cur_q  <= cur_d;
         pwr_q  <= pwr_d;
      end
   end

   assign cif.done    = done_q;
   assign cif.current = cur_q;
   assign cif.power   = pwr_q;
endmodule
`default_nettype wire

// ===== rtl/sbcs_calc_if.sv
// Purpose: Carries operands and results between sequencer and arithmetic unit
// Assumes: One clock domain
// Notes:   start is a one-cycle pulse, done follows it
`timescale 1ns/1ps
`default_nettype none
interface sbcs_calc_if;
   logic               start;
   logic signed [15:0] shunt;
   logic signed [15:0] bus;
   logic        [15:0] cal;
   logic               done;
   logic signed [15:0] current;
   logic signed [15:0] power;
   modport seq  (output start, shunt, bus, cal, input done, current, power);
   modport calc (input start, shunt, bus, cal, output done, current, power);
endinterface
`default_nettype wire

// ===== rtl/sbcs_pkg.sv
// Purpose: Shared constants and types of the shunt and bus conversion sequencer
// Assumes: 40 MHz system clock, 16-bit register port
// Notes:   Mode code bit 0 enables shunt, bit 1 enables bus, bit 2 selects continuous
package sbcs_pkg;
   localparam int          DW             = 16;
   localparam int          AW             = 8;
   // Register offsets
   localparam logic [7:0]  OFF_CONFIG     = 8'h00;
   localparam logic [7:0]  OFF_STATUS     = 8'h04;
   localparam logic [7:0]  OFF_SHUNT      = 8'h08;
   localparam logic [7:0]  OFF_BUS        = 8'h0C;
   localparam logic [7:0]  OFF_CAL        = 8'h10;
   localparam logic [7:0]  OFF_CURRENT    = 8'h14;
   localparam logic [7:0]  OFF_POWER      = 8'h18;
   localparam logic [7:0]  OFF_IRQ_STAT   = 8'h1C;
   localparam logic [7:0]  OFF_IRQ_MASK   = 8'h20;
   // Configuration fields
   localparam int          CFG_MODE_LSB   = 0;
   localparam int          CFG_SAVG_LSB   = 3;
   localparam int          CFG_BAVG_LSB   = 6;
   localparam logic [15:0] CONFIG_RESET   = 16'h0007;
   localparam logic [15:0] CAL_RESET      = 16'h0000;
   // Mode codes
   localparam logic [2:0]  MODE_PD        = 3'h0;
   localparam logic [2:0]  MODE_OFF       = 3'h4;
   localparam int          MODE_SH_BIT    = 0;
   localparam int          MODE_BUS_BIT   = 1;
   localparam int          MODE_CONT_BIT  = 2;
   // Status and interrupt bits
   localparam int          ST_READY_BIT   = 0;
   localparam int          ST_BUSY_BIT    = 1;
   localparam int          ST_RECOV_BIT   = 2;
   localparam int          IRQ_READY_BIT  = 0;
   localparam int          IRQ_LOST_BIT   = 1;
   // Arithmetic scaling
   localparam int          CUR_SHIFT      = 12;
   localparam logic signed [33:0] PWR_DIV = 34'sh0000_1388;
   // Timing
   localparam int          CLK_HZ         = 40_000_000;
   localparam int          RECOVER_US     = 40;
   localparam int          RECOVER_CYC    = (RECOVER_US * (CLK_HZ / 1_000_000) > 0) ?
                                            RECOVER_US * (CLK_HZ / 1_000_000) : 1;
   localparam int          REC_W          = 11;

   typedef enum logic [3:0] {
      SBCS_IDLE    = 4'b0001,
      SBCS_RECOVER = 4'b0010,
      SBCS_SHUNT   = 4'b0100,
      SBCS_BUS     = 4'b1000
   } sbcs_state_t;
endpackage

// ===== rtl/sbcs_top.sv
// Purpose: Conversion sequencer of a shunt current and power monitor
// Assumes: Converter front end answers each start with one done pulse and data
// Notes:   Register port with one-cycle read latency; level interrupt output
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Continuous shunt-and-bus mode repeatedly converts shunt over its averaging count.
// - After the shunt samples, bus voltage is averaged over its own count.
// - Shunt-only and bus-only modes exist, continuous or triggered.
// - Current and power are computed alongside conversion, adding no conversion time.
// - Leaving power-down waits a 40 us recovery before measuring.
// - ADC-off mode halts all conversion until another mode is written.
// - Every write of a triggered mode starts one single-shot conversion.
// - Ready flag sets only after conversions, averaging and multiplication finish.
// - Ready clears on config write except off modes, status read, or pin trigger.
module sbcs_top
   import sbcs_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          arst_n,
   input  wire logic [AW-1:0] reg_addr,
   input  wire logic [DW-1:0] reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [DW-1:0] reg_rdata,
   input  wire logic          convert_n,
   output logic               adc_start,
   output logic               adc_sel_bus,
   output logic               adc_power_down,
   input  wire logic          adc_done,
   input  wire logic [15:0]   adc_data,
   output logic               irq
);
   sbcs_calc_if cif ();

   sbcs_state_t        state_q,    state_d;
   logic [2:0]         mode_q,     mode_d;
   logic [2:0]         savg_q,     savg_d;
   logic [2:0]         bavg_q,     bavg_d;
   logic [15:0]        cal_q,      cal_d;
   logic signed [15:0] shunt_q,    shunt_d;
   logic signed [15:0] bus_q,      bus_d;
   logic signed [22:0] acc_q,      acc_d;
   logic [7:0]         cnt_q,      cnt_d;
   logic [REC_W-1:0]   rec_q,      rec_d;
   logic               ready_q,    ready_d;
   logic               trig_q,     trig_d;
   logic               active_q,   active_d;
   logic               conv_prev_q;
   logic               start_q,    start_d;
   logic               sel_q,      sel_d;
   logic               pd_q,       pd_d;
   logic               calc_go_q,  calc_go_d;
   logic [1:0]         istat_q,    istat_d;
   logic [1:0]         imask_q,    imask_d;
   logic               irq_q,      irq_d;
   logic [DW-1:0]      rdata_q,    rdata_d;

   logic               cfg_wr, stat_rd, pin_trig, new_trig;
   logic [2:0]         wmode;
   logic [7:0]         target;
   logic signed [22:0] acc_sum, acc_avg;
   logic [1:0]         ev;

   sbcs_calc u_calc
   (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .cif     (cif)
   );

   // Operands come from result registers so the next cycle may run meanwhile
   assign cif.start = calc_go_q;
   assign cif.shunt = shunt_q;
   assign cif.bus   = bus_q;
   assign cif.cal   = cal_q;

   always_comb
   begin
      cfg_wr   = reg_wr && (reg_addr == OFF_CONFIG);
      stat_rd  = reg_rd && (reg_addr == OFF_STATUS);
      wmode    = reg_wdata[CFG_MODE_LSB +: 3];
      // Falling edge of the pin; the pin's low width is the driver's duty
      pin_trig = conv_prev_q && !convert_n && !mode_q[MODE_CONT_BIT]
                 && (mode_q != MODE_PD);
      new_trig = 1'b0;
      ev       = 2'b00;

      state_d   = state_q;
      mode_d    = mode_q;
      savg_d    = savg_q;
      bavg_d    = bavg_q;
      cal_d     = cal_q;
      shunt_d   = shunt_q;
      bus_d     = bus_q;
      acc_d     = acc_q;
      cnt_d     = cnt_q;
      rec_d     = rec_q;
      ready_d   = ready_q;
      trig_d    = trig_q;
      active_d  = active_q;
      start_d   = 1'b0;
      sel_d     = sel_q;
      pd_d      = pd_q;
      calc_go_d = 1'b0;
      imask_d   = imask_q;

      target  = 8'h01 << (state_q == SBCS_BUS ? bavg_q : savg_q);
      // Samples are signed, so extend the sign before accumulating
      acc_sum = acc_q + 23'($signed(adc_data));
      acc_avg = acc_sum >>> (state_q == SBCS_BUS ? bavg_q : savg_q);

      // Conversion sequencing
      unique case (state_q)
         SBCS_IDLE:
         begin
            if (mode_q != MODE_PD && mode_q != MODE_OFF
                && (mode_q[MODE_CONT_BIT] || trig_q))
            begin
               trig_d  = 1'b0;
               acc_d   = 23'sh000000;
               cnt_d   = 8'h00;
               start_d = 1'b1;
               if (mode_q[MODE_SH_BIT])
               begin
                  state_d = SBCS_SHUNT;
                  sel_d   = 1'b0;
               end
               else
               begin
                  state_d = SBCS_BUS;
                  sel_d   = 1'b1;
               end
            end
         end
         SBCS_RECOVER:
         begin
            // Front end settles before any conversion is trusted
            if (rec_q == REC_W'(RECOVER_CYC - 1))
               state_d = SBCS_IDLE;
            else
               rec_d = rec_q + REC_W'(1);
         end
         SBCS_SHUNT, SBCS_BUS:
         begin
            if (adc_done)
            begin
               acc_d   = acc_sum;
               cnt_d   = cnt_q + 8'h01;
               start_d = 1'b1;
               if (cnt_q + 8'h01 == target)
               begin
                  acc_d = 23'sh000000;
                  cnt_d = 8'h00;
                  if (state_q == SBCS_SHUNT)
                  begin
                     shunt_d = acc_avg[15:0];
                     if (mode_q[MODE_BUS_BIT])
                     begin
                        state_d = SBCS_BUS;
                        sel_d   = 1'b1;
                     end
                  end
                  else
                     bus_d = acc_avg[15:0];
                  if (state_q == SBCS_BUS || !mode_q[MODE_BUS_BIT])
                  begin
                     // Cycle done: multiply in the background, restart or stop
                     calc_go_d = 1'b1;
                     active_d  = 1'b1;
                     if (mode_q[MODE_CONT_BIT])
                     begin
                        state_d = mode_q[MODE_SH_BIT] ? SBCS_SHUNT : SBCS_BUS;
                        sel_d   = !mode_q[MODE_SH_BIT];
                     end
                     else
                     begin
                        state_d = SBCS_IDLE;
                        start_d = 1'b0;
                     end
                  end
               end
            end
         end
      endcase

      if (pin_trig)
      begin
         new_trig = 1'b1;
         ready_d  = 1'b0;
      end

      if (stat_rd)
         ready_d = 1'b0;

      // A config write aborts the running cycle and applies at once
      if (cfg_wr)
      begin
         mode_d  = wmode;
         savg_d  = reg_wdata[CFG_SAVG_LSB +: 3];
         bavg_d  = reg_wdata[CFG_BAVG_LSB +: 3];
         state_d = SBCS_IDLE;
         start_d = 1'b0;
         // Select only moves together with a sample request
         sel_d   = sel_q;
         trig_d  = 1'b0;
         pd_d    = (wmode == MODE_PD);
         if (wmode != MODE_PD && wmode != MODE_OFF)
         begin
            ready_d = 1'b0;
            if (!wmode[MODE_CONT_BIT])
               new_trig = 1'b1;
         end
         if (pd_q && wmode != MODE_PD)
         begin
            state_d = SBCS_RECOVER;
            rec_d   = '0;
         end
      end

      if (new_trig)
      begin
         if (state_q != SBCS_IDLE && !cfg_wr)
            ev[IRQ_LOST_BIT] = 1'b1;
         else
            trig_d = 1'b1;
      end

      // Set after the clears so a finishing multiply is never lost
      if (cif.done && active_q)
      begin
         ready_d  = 1'b1;
         active_d = 1'b0;
         ev[IRQ_READY_BIT] = 1'b1;
      end
      if (cfg_wr)
         active_d = 1'b0;

      if (reg_wr && reg_addr == OFF_CAL)
         cal_d = reg_wdata;
      if (reg_wr && reg_addr == OFF_IRQ_MASK)
         imask_d = reg_wdata[1:0];
      istat_d = istat_q;
      if (reg_wr && reg_addr == OFF_IRQ_STAT)
         istat_d = istat_q & ~reg_wdata[1:0];
      istat_d = istat_d | ev;
      irq_d   = |(istat_d & imask_d);

      rdata_d = '0;
      if (reg_rd)
      begin
         unique case (reg_addr)
            OFF_CONFIG:   rdata_d = DW'({bavg_q, savg_q, mode_q});
            OFF_STATUS:   rdata_d = DW'({state_q == SBCS_RECOVER,
                                         state_q != SBCS_IDLE, ready_q});
            OFF_SHUNT:    rdata_d = shunt_q;
            OFF_BUS:      rdata_d = bus_q;
            OFF_CAL:      rdata_d = cal_q;
            OFF_CURRENT:  rdata_d = cif.current;
            OFF_POWER:    rdata_d = cif.power;
            OFF_IRQ_STAT: rdata_d = DW'(istat_q);
            OFF_IRQ_MASK: rdata_d = DW'(imask_q);
            default:      rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q     <= SBCS_IDLE;
         mode_q      <= CONFIG_RESET[CFG_MODE_LSB +: 3];
         savg_q      <= CONFIG_RESET[CFG_SAVG_LSB +: 3];
         bavg_q      <= CONFIG_RESET[CFG_BAVG_LSB +: 3];
         cal_q       <= CAL_RESET;
         shunt_q     <= 16'sh0000;
         bus_q       <= 16'sh0000;
         acc_q       <= 23'sh000000;
         cnt_q       <= 8'h00;
         rec_q       <= '0;
         ready_q     <= 1'b0;
         trig_q      <= 1'b0;
         active_q    <= 1'b0;
         conv_prev_q <= 1'b1;
         start_q     <= 1'b0;
         sel_q       <= 1'b0;
         pd_q        <= 1'b0;
         calc_go_q   <= 1'b0;
         istat_q     <= 2'h0;
         imask_q     <= 2'h0;
         irq_q       <= 1'b0;
         rdata_q     <= '0;
      end
      else
      begin
         state_q     <= state_d;
         mode_q      <= mode_d;
         savg_q      <= savg_d;
         bavg_q      <= bavg_d;
         cal_q       <= cal_d;
         shunt_q     <= shunt_d;
         bus_q       <= bus_d;
         acc_q       <= acc_d;
         cnt_q       <= cnt_d;
         rec_q       <= rec_d;
         ready_q     <= ready_d;
         trig_q      <= trig_d;
         active_q    <= active_d;
         conv_prev_q <= convert_n;
         start_q     <= start_d;
         sel_q       <= sel_d;
         pd_q        <= pd_d;
         calc_go_q   <= calc_go_d;
         istat_q     <= istat_d;
         imask_q     <= imask_d;
         irq_q       <= irq_d;
         rdata_q     <= rdata_d;
      end
   end

   assign reg_rdata      = rdata_q;
   assign adc_start      = start_q;
   assign adc_sel_bus    = sel_q;
   assign adc_power_down = pd_q;
   assign irq            = irq_q;
endmodule
`default_nettype wire

// ===== tb/sbcs_adc_model.sv
// Purpose: Converter front end answering each sample request
// Assumes: One request outstanding; a new request restarts it
// Notes:   Data toggle outside the done cycle, so stale values never match
`timescale 1ns/1ps
`default_nettype none
module sbcs_adc_model
(
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic [3:0]  dly,
   input  wire logic        adc_start,
   input  wire logic        adc_sel_bus,
   input  wire logic        adc_power_down,
   output logic             adc_done,
   output logic      [15:0] adc_data
);
   localparam logic [15:0] SH_V = 16'h0100;
   localparam logic [15:0] BU_V = 16'h0200;
   logic [3:0] cnt_q;
   logic       sel_q;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q    <= 4'h0;
         sel_q    <= 1'b0;
         adc_done <= 1'b0;
         adc_data <= 16'h0000;
      end
      else
      begin
         adc_done <= 1'b0;
         adc_data <= ~adc_data;
         if (adc_power_down)
            cnt_q <= 4'h0;
         else if (adc_start)
         begin
            cnt_q <= dly;
            sel_q <= adc_sel_bus;
         end
         else if (cnt_q == 4'h1)
         begin
            adc_done <= 1'b1;
            adc_data <= sel_q ? BU_V : SH_V;
            cnt_q    <= 4'h0;
         end
         else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
      end
   end
endmodule
`default_nettype wire

// ===== tb/sbcs_tb_top.sv
// Purpose: Register-level test of the conversion sequencer
// Assumes: Front end model answers with fixed shunt and bus codes
// Notes:   Cal 0x1000 makes current equal the shunt code
`timescale 1ns/1ps
`default_nettype none
module sbcs_tb_top
   import sbcs_pkg::*;
;
   logic        clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, convert_n = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, adc_data, d;
   logic        adc_start, adc_sel_bus, adc_power_down, adc_done, irq;
   logic [3:0]  dly = 4'h9;
   logic [2:0]  modes [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
   int          err_total = 0, tests_run = 0, n;

   sbcs_top i_dut (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .convert_n,
      .adc_start, .adc_sel_bus, .adc_power_down, .adc_done, .adc_data, .irq);
   sbcs_adc_model i_adc (.clk_sys, .arst_n, .dly, .adc_start, .adc_sel_bus, .adc_power_down, .adc_done, .adc_data);

   initial forever #12.5 clk_sys = ~clk_sys;

   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
      rd(a);
      chk(nm, e, d);
   endtask
   // Polling read also clears the flag, so callers see it once
   task automatic wait_rdy;
      d = 16'h0000;
      for (int i = 0; i < 3000 && d[0] !== 1'b1; i++) rd(OFF_STATUS);
      chk("ready", 16'h0001, {15'h0, d[0]});
   endtask
   task automatic cnt_starts;
      n = 0;
      repeat (100) begin @(posedge clk_sys); #1 n += int'(adc_start); end
   endtask

   initial
   begin
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      rchk("config", OFF_CONFIG, CONFIG_RESET);
      rchk("cal", OFF_CAL, CAL_RESET);
      rchk("unmapped", 8'h24, 16'h0000);
      wr(OFF_CAL, 16'h1000);
      wr(OFF_IRQ_MASK, 16'h0001);
      // Drop a flag left from a cycle computed with the old calibration
      rd(OFF_STATUS);
      wait_rdy;
      chk("irq", 16'h0001, {15'h0, irq});
      rchk("shunt", OFF_SHUNT, 16'h0100);
      rchk("bus", OFF_BUS, 16'h0200);
      rchk("current", OFF_CURRENT, 16'h0100);
      rchk("power", OFF_POWER, 16'h001A);
      dly <= 4'h1;
      wr(OFF_CONFIG, 16'h008B);
      rd(OFF_STATUS);
      chk("cfg clears", 16'h0000, {15'h0, d[0]});
      wait_rdy;
      cnt_starts;
      chk("single shot", 16'h0000, 16'(n));
      rchk("kept", OFF_SHUNT, 16'h0100);
      wr(OFF_IRQ_STAT, 16'h0001);
      repeat (2) @(posedge clk_sys);
      chk("irq clear", 16'h0000, {15'h0, irq});
      wr(OFF_CONFIG, 16'h008B);
      repeat (100) @(posedge clk_sys);
      rchk("same mode", OFF_STATUS, 16'h0001);
      wr(OFF_IRQ_MASK, 16'h0000);
      repeat (2) @(posedge clk_sys);
      chk("irq masked", 16'h0000, {15'h0, irq});
      repeat (100) @(posedge clk_sys);
      convert_n <= 1'b0;
      rd(OFF_STATUS);
      chk("pin clears", 16'h0000, {15'h0, d[0]});
      repeat (170) @(posedge clk_sys);
      convert_n <= 1'b1;
      wait_rdy;
      foreach (modes[i])
      begin
         wr(OFF_CONFIG, {13'h0, modes[i]});
         wait_rdy;
      end
      wr(OFF_CONFIG, 16'h0003);
      repeat (100) @(posedge clk_sys);
      wr(OFF_CONFIG, {13'h0, MODE_OFF});
      rd(OFF_STATUS);
      chk("off keeps", 16'h0001, {15'h0, d[0]});
      cnt_starts;
      chk("off idle", 16'h0000, 16'(n));
      rchk("off result", OFF_BUS, 16'h0200);
      wr(OFF_CONFIG, {13'h0, MODE_PD});
      repeat (2) @(posedge clk_sys);
      chk("pd pin", 16'h0001, {15'h0, adc_power_down});
      wr(OFF_CONFIG, 16'h0007);
      n = 0;
      while (n < 3000 && adc_start !== 1'b1) begin @(posedge clk_sys); #1 n++; end
      chk("recovery", 16'h0001, {15'h0, n >= RECOVER_CYC - 1 && n < 3000});
      wait_rdy;
      stop_test;
   end

   initial
   begin
      repeat (60000) @(posedge clk_sys);
      err_total++;
      stop_test;
   end
endmodule
`default_nettype wire

// ===== tb/sbcs_top_properties.sv
// Purpose: Port-level checks of the conversion sequencer
// Assumes: Config writes are never closer than one idle cycle
// Notes:   Mode and averaging are tracked from config writes
`timescale 1ns/1ps
`default_nettype none
module sbcs_top_properties
   import sbcs_pkg::*;
(
   input wire logic          clk_sys,
   input wire logic          arst_n,
   input wire logic [AW-1:0] reg_addr,
   input wire logic [DW-1:0] reg_wdata,
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [DW-1:0] reg_rdata,
   input wire logic          convert_n,
   input wire logic          adc_start,
   input wire logic          adc_sel_bus,
   input wire logic          adc_power_down,
   input wire logic          adc_done,
   input wire logic [15:0]   adc_data,
   input wire logic          irq
);
   logic [2:0]  mode_q;
   logic [2:0]  savg_q;
   logic [2:0]  bavg_q;
   logic [7:0]  sh_q;
   logic [7:0]  bu_q;
   logic [10:0] rec_q;
   wire         cfg_wr = reg_wr && reg_addr == OFF_CONFIG;
   wire  [2:0]  wmode  = reg_wdata[2:0];

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_q <= CONFIG_RESET[2:0];
         savg_q <= 3'h0;
         bavg_q <= 3'h0;
         sh_q   <= 8'h00;
         bu_q   <= 8'h00;
         rec_q  <= 11'h000;
      end
      else if (cfg_wr)
      begin
         mode_q <= wmode;
         savg_q <= reg_wdata[5:3];
         bavg_q <= reg_wdata[8:6];
         sh_q   <= 8'h00;
         bu_q   <= 8'h00;
         // Only a write that leaves power-down opens the quiet window
         rec_q  <= (mode_q == MODE_PD && wmode != MODE_PD) ? 11'h001 : 11'h000;
      end
      else
      begin
         rec_q <= (rec_q != 11'h000 && rec_q < 11'(RECOVER_CYC - 1)) ? rec_q + 11'h001 : 11'h000;
         if (adc_start && adc_sel_bus)
            bu_q <= bu_q + 8'h01;
         else if (adc_start)
         begin
            sh_q <= (bu_q != 8'h00) ? 8'h01 : sh_q + 8'h01;
            bu_q <= 8'h00;
         end
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   sequence s_quiet;
      (!adc_start)[*8];
   endsequence
   sequence s_off_write;
      cfg_wr && wmode == MODE_OFF;
   endsequence

   property p_start_pulse; adc_start |=> !adc_start; endproperty
   property p_sel_hold; !adc_start |-> $stable(adc_sel_bus); endproperty
   property p_bus_after_shunt; adc_start && adc_sel_bus && mode_q[0] |-> sh_q == (8'h01 << savg_q); endproperty
   property p_shunt_after_bus; adc_start && !adc_sel_bus && bu_q != 8'h00 |-> bu_q == (8'h01 << bavg_q); endproperty
   property p_cont_next; adc_done && mode_q[2] && mode_q != MODE_OFF && !cfg_wr |=> adc_start; endproperty
   property p_off_quiet; s_off_write |-> ##2 s_quiet; endproperty
   property p_pd_level; cfg_wr && wmode == MODE_PD |-> ##[1:2] adc_power_down; endproperty
   property p_recover; adc_start |-> rec_q == 11'h000; endproperty
   property p_trig_start; cfg_wr && !wmode[2] && wmode != MODE_PD && mode_q != MODE_PD |-> ##[1:3] adc_start;
   endproperty

   a_start_pulse: assert property (p_start_pulse) else $error("sample request wider than one cycle");
   a_sel_hold: assert property (p_sel_hold) else $error("sample select moved between requests");
   a_bus_after_shunt: assert property (p_bus_after_shunt) else $error("bus sample before shunt count");
   a_shunt_after_bus: assert property (p_shunt_after_bus) else $error("bus sample count wrong");
   a_cont_next: assert property (p_cont_next) else $error("continuous run stalled");
   a_off_quiet: assert property (p_off_quiet) else $error("sampling while converter off");
   a_pd_level: assert property (p_pd_level) else $error("power-down not applied");
   a_recover: assert property (p_recover) else $error("sample during recovery");
   a_trig_start: assert property (p_trig_start) else $error("triggered write started nothing");
endmodule
bind sbcs_top sbcs_top_properties i_props (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .convert_n, .adc_start, .adc_sel_bus, .adc_power_down, .adc_done, .adc_data, .irq);
`default_nettype wire
